// ### shared/rfs_defs.svh
// constants and behaviour summary for the regulator fault supervisor
// Behaviour
// (RULE_01) upward voltage change forces full four-phase operation
// (RULE_02) downward voltage change keeps phase count and conduction mode
// (RULE_03) light-load downward step blocks low sides for 4 PWM pulses
// (RULE_04) slew compensation bits decoded from both strap pins
// (RULE_05) diode emulation uses modified ramp; normal ramp from strap a
// (RULE_06) monitor voltage 0..3.19375V into 511 steps of 6.25mV
// (RULE_07) fast transient pulse, one on-time wide, overrides active phases
// (RULE_08) sustained trip only after trigger delay above threshold
// (RULE_09) peak trip fires at once on cycle current above threshold
// (RULE_10) any trip asserts alert low and starts action delay
// (RULE_11) after action delay, still over: all drivers off
// (RULE_12) over-voltage limit 0.9V+325mV below 0.9V, else ref+325mV; latches
// (RULE_13) over-voltage watch starts only after power-on reset
// (RULE_14) over-voltage latched: low sides on, high sides off
// (RULE_15) over or under-voltage latch starts other rail soft shutdown
// (RULE_16) over-voltage comparator must hold 1us before acceptance
// (RULE_17) latched over-voltage, output below 0V: low sides off until above
// (RULE_18) negative-voltage guard active only while over-voltage latched
// (RULE_19) output 500mV below reference sets under-voltage latch, all off
// (RULE_20) under-voltage comparator must hold 3us before latching
// (RULE_21) supply below threshold for 3us: lockout, all drivers off
// (RULE_22) commands to the second rail rejected while it is strapped off
// (RULE_23) voltage latches hold until reset or enable cycle; top priority (code gates lockout, disable and soft-off ahead of them)
`ifndef RFS_DEFS_SVH
`define RFS_DEFS_SVH
`define RFS_CLK_MHZ 40
`define RFS_OV_FILT_NS 1000
`define RFS_UV_FILT_NS 3000
`define RFS_LO_FILT_NS 3000
`define RFS_OV_CYC ((`RFS_OV_FILT_NS * `RFS_CLK_MHZ + 999) / 1000)
`define RFS_UV_CYC ((`RFS_UV_FILT_NS * `RFS_CLK_MHZ + 999) / 1000)
`define RFS_LO_CYC ((`RFS_LO_FILT_NS * `RFS_CLK_MHZ + 999) / 1000)
`define RFS_OV_FLOOR_MV 900
`define RFS_OV_MARGIN_MV 325
`define RFS_UV_MARGIN_MV 500
`define RFS_ADC_LSB_EIGHTHS 50
`define RFS_ADC_MAX 511
`define RFS_DV_BLOCK_PULSES 4
`define RFS_ADDR_CTRL 12'h000
`define RFS_ADDR_STATUS 12'h004
`define RFS_ADDR_LOAD 12'h008
`define RFS_ADDR_OCP 12'h00c
`define RFS_ADDR_VCMD 12'h010
`define RFS_ADDR_STRAP 12'h014
`define RFS_CTRL_RESET 32'h0000_2003
`define RFS_OCP_RESET 32'h0064_0028
`endif

// ### shared/rfs_pkg.sv
// types shared by the regulator fault supervisor
package rfs_pkg;
  typedef struct packed {
    logic [3:0] hs;
    logic [3:0] ls;
  } rfs_gate_t;
  typedef enum logic [1:0] {
    RFS_OC_IDLE = 2'b00,
    RFS_OC_TRIG = 2'b01,
    RFS_OC_ACT = 2'b10,
    RFS_OC_OFF = 2'b11
  } rfs_oc_t;
endpackage : rfs_pkg

// ### rtl/rfs_supervisor.sv
// fault, voltage-change and reporting supervisor of the core rail
`timescale 1ns/1ps
`include "rfs_defs.svh"
module rfs_supervisor #(
  parameter int PHASES = 4
) (
  input wire logic pclk, // bus and core clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic [1:0] strap_pin_a, // ramp / slew strap
  input wire logic [1:0] strap_pin_b, // slew strap
  input wire logic aux_phase1_sense_neg_high, // second rail strapped off
  input wire logic [15:0] current_monitor_pin, // volts in 0.125mV units
  input wire logic signed [12:0] output_sense_pin, // sensed output, mV
  input wire logic supply_below_por, // supply comparator
  input wire logic avg_over, // averaged current above threshold
  input wire logic peak_over, // cycle current above threshold
  input wire logic fast_transient_det, // fast load transient seen
  input wire logic light_load, // light-load indication
  input wire logic pwm_pulse, // one pulse per PWM cycle
  input wire rfs_pkg::rfs_gate_t pwm_in, // modulator gate requests
  input wire logic other_rail_fault, // other rail latched a fault
  output rfs_pkg::rfs_gate_t gate_out, // gate driver enables
  output logic over_current_alert_n, // over-current alert, low
  output logic other_rail_shutdown, // soft shutdown of other rail
  output logic diode_emulation, // diode emulation active
  output logic [1:0] ramp_amp, // continuous-conduction ramp
  output logic [3:0] slew_comp_bits, // slew compensation setting
  output logic fast_transient_pulse, // on-time override pulse
  output logic [11:0] core_vref_mv, // core reference, mV
  output logic [11:0] nb_vref_mv // second rail reference, mV
);
  import rfs_pkg::*;

  localparam int OVC = `RFS_OV_CYC;
  localparam int UVC = `RFS_UV_CYC;
  localparam int LOC = `RFS_LO_CYC;

  // refuse phase counts the gate masks cannot serve
  if (PHASES < 1 || PHASES > 4)
  begin : g_bad_phases
    $error("PHASES must be 1 to 4");
  end

  // mask of active phases for a phase count minus one
  function automatic logic [3:0] phase_mask(input logic [1:0] n);
    phase_mask = 4'hf >> (2'd3 - n);
  endfunction : phase_mask

  // saturating filter step toward a limit
  function automatic logic [7:0] filt_step(input logic in,
                                           input logic [7:0] c,
                                           input int lim);
    if (!in)
      filt_step = 8'h00;
    else if (c < 8'(lim))
      filt_step = c + 8'h01;
    else
      filt_step = c;
  endfunction : filt_step

  logic [31:0] ctrl_q, ocp_q;
  logic enable, en_q;
  logic [1:0] phase_q;
  logic [7:0] ton;
  logic por_done_q, nb_off_q, reject_q;
  logic [3:0] strap_q;
  logic [1:0] ramp_q;
  logic [8:0] load_q;
  logic [7:0] ov_c_q, uv_c_q, lo_c_q;
  logic ov_q, uv_q, lo_q, soft_off_q, nvg_q;
  rfs_oc_t oc_q;
  logic [15:0] oc_cnt_q;
  logic [2:0] blk_cnt_q;
  logic [7:0] qr_cnt_q;
  logic [12:0] ov_lim, uv_lim;
  logic wr, rd_setup, mapped, vcmd_wr, en_rise;
  logic [11:0] new_mv;
  rfs_gate_t gate_d;

  assign enable = ctrl_q[0];
  assign ton = ctrl_q[15:8];
  assign en_rise = enable & ~en_q;

  // apb decode; always ready, error on unmapped address
  assign mapped = paddr == `RFS_ADDR_CTRL || paddr == `RFS_ADDR_STATUS ||
                  paddr == `RFS_ADDR_LOAD || paddr == `RFS_ADDR_OCP ||
                  paddr == `RFS_ADDR_VCMD || paddr == `RFS_ADDR_STRAP;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign vcmd_wr = wr & (paddr == `RFS_ADDR_VCMD);
  assign new_mv = pwdata[11:0];

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `RFS_CTRL_RESET;
      ocp_q <= `RFS_OCP_RESET;
      en_q <= 1'b0;
    end
    else
    begin
      en_q <= enable;
      if (wr && paddr == `RFS_ADDR_CTRL)
        ctrl_q <= {16'h0000, pwdata[15:8], 5'h00, pwdata[2:0]};
      if (wr && paddr == `RFS_ADDR_OCP)
        ocp_q <= pwdata;
    end
  end

  // read data captured in setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
    begin
      unique case (paddr)
        `RFS_ADDR_CTRL: prdata <= ctrl_q;
        `RFS_ADDR_STATUS: prdata <= {18'h00000, phase_q, diode_emulation,
          reject_q, nb_off_q, nvg_q, oc_q, ~over_current_alert_n,
          soft_off_q, lo_q, uv_q, ov_q, por_done_q};
        `RFS_ADDR_LOAD: prdata <= {23'h000000, load_q};
        `RFS_ADDR_OCP: prdata <= ocp_q;
        `RFS_ADDR_VCMD: prdata <= {8'h00, nb_vref_mv, core_vref_mv};
        `RFS_ADDR_STRAP: prdata <= {26'h0000000, ramp_q, strap_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // straps and second-rail disable caught after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_done_q <= 1'b0;
      strap_q <= 4'h0;
      ramp_q <= 2'b00;
      nb_off_q <= 1'b0;
    end
    else if (!por_done_q)
    begin
      por_done_q <= 1'b1;
      // (RULE_04) slew bits decode
      strap_q <= {strap_pin_b, strap_pin_a[1:0] ^ strap_pin_b};
      // (RULE_05) ramp from strap
      ramp_q <= strap_pin_a;
      nb_off_q <= aux_phase1_sense_neg_high;
    end
  end
  assign slew_comp_bits = strap_q;

  // voltage commands; bit 16 selects the second rail
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_vref_mv <= 12'h000;
      nb_vref_mv <= 12'h000;
      reject_q <= 1'b0;
    end
    else
    begin
      if (vcmd_wr && !pwdata[16])
        core_vref_mv <= new_mv;
      // (RULE_22) reject when strapped off
      if (vcmd_wr && pwdata[16] && !nb_off_q)
        nb_vref_mv <= new_mv;
      if (vcmd_wr && pwdata[16] && nb_off_q)
        reject_q <= 1'b1;
      else if (wr && paddr == `RFS_ADDR_STATUS && pwdata[8])
        reject_q <= 1'b0;
    end
  end

  // phase count and light-load low-side blocking on voltage changes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q <= 2'(PHASES - 1);
      blk_cnt_q <= 3'h0;
    end
    else
    begin
      if (vcmd_wr && !pwdata[16] && new_mv > core_vref_mv)
        // (RULE_01) up: four phases
        phase_q <= 2'(PHASES - 1);
      else if (vcmd_wr && !pwdata[16] && new_mv < core_vref_mv)
        // (RULE_02) down: hold state
        phase_q <= phase_q;
      else if (wr && paddr == `RFS_ADDR_CTRL &&
               3'(pwdata[2:1]) < 3'(PHASES))
        phase_q <= pwdata[2:1];
      // (RULE_03) block low sides, 4 pulses
      if (vcmd_wr && !pwdata[16] && new_mv < core_vref_mv && light_load)
        blk_cnt_q <= 3'(`RFS_DV_BLOCK_PULSES);
      else if (pwm_pulse && blk_cnt_q != 3'h0)
        blk_cnt_q <= blk_cnt_q - 3'h1;
    end
  end

  // (RULE_05) modified ramp in emulation
  assign diode_emulation = light_load & (phase_q == 2'b00);
  assign ramp_amp = diode_emulation ? 2'b00 : ramp_q;

  // (RULE_06) monitor conversion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      load_q <= 9'h000;
    else if (current_monitor_pin / 16'(`RFS_ADC_LSB_EIGHTHS) >
             16'(`RFS_ADC_MAX))
      load_q <= 9'(`RFS_ADC_MAX);
    else
      load_q <= 9'(current_monitor_pin / 16'(`RFS_ADC_LSB_EIGHTHS));
  end

  // (RULE_07) fast transient pulse of on-time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      qr_cnt_q <= 8'h00;
    else if (fast_transient_det && qr_cnt_q == 8'h00)
      qr_cnt_q <= ton;
    else if (qr_cnt_q != 8'h00)
      qr_cnt_q <= qr_cnt_q - 8'h01;
  end
  assign fast_transient_pulse = qr_cnt_q != 8'h00;

  // over-current state machine: trigger delay then action delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oc_q <= RFS_OC_IDLE;
      oc_cnt_q <= 16'h0000;
    end
    else if (en_rise)
    begin
      oc_q <= RFS_OC_IDLE;
      oc_cnt_q <= 16'h0000;
    end
    else
    begin
      unique case (oc_q)
        RFS_OC_IDLE:
        begin
          // (RULE_09) peak trip immediate
          if (peak_over)
          begin
            oc_q <= RFS_OC_ACT;
            oc_cnt_q <= ocp_q[31:16];
          end
          else if (avg_over)
          begin
            oc_q <= RFS_OC_TRIG;
            oc_cnt_q <= ocp_q[15:0];
          end
        end
        RFS_OC_TRIG:
        begin
          // (RULE_08) sustained trip after delay
          if (peak_over || (avg_over && oc_cnt_q == 16'h0000))
          begin
            oc_q <= RFS_OC_ACT;
            oc_cnt_q <= ocp_q[31:16];
          end
          else if (!avg_over)
            oc_q <= RFS_OC_IDLE;
          else
            oc_cnt_q <= oc_cnt_q - 16'h0001;
        end
        RFS_OC_ACT:
        begin
          // (RULE_11) still over after delay
          if (oc_cnt_q != 16'h0000)
            oc_cnt_q <= oc_cnt_q - 16'h0001;
          else if (avg_over || peak_over)
            oc_q <= RFS_OC_OFF;
          else
            oc_q <= RFS_OC_IDLE;
        end
        RFS_OC_OFF: oc_q <= RFS_OC_OFF;
      endcase
    end
  end
  // (RULE_10) alert on trip
  assign over_current_alert_n = ~(oc_q == RFS_OC_ACT || oc_q == RFS_OC_OFF);

  // (RULE_12) over and under-voltage limits
  assign ov_lim = core_vref_mv < 12'(`RFS_OV_FLOOR_MV) ?
    13'(`RFS_OV_FLOOR_MV + `RFS_OV_MARGIN_MV) :
    13'(core_vref_mv) + 13'(`RFS_OV_MARGIN_MV);
  assign uv_lim = 13'(core_vref_mv) - 13'(`RFS_UV_MARGIN_MV);

  // deglitch filters for the three comparators
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ov_c_q <= 8'h00;
      uv_c_q <= 8'h00;
      lo_c_q <= 8'h00;
    end
    else
    begin
      // (RULE_13) watch after reset done
      // (RULE_16) 1us hold
      ov_c_q <= filt_step(por_done_q &&
                          output_sense_pin > $signed(ov_lim), ov_c_q, OVC);
      // (RULE_20) 3us hold
      uv_c_q <= filt_step(por_done_q && enable &&
                          output_sense_pin <= $signed(uv_lim), uv_c_q, UVC);
      // (RULE_21) 3us supply qualify
      lo_c_q <= filt_step(supply_below_por, lo_c_q, LOC);
    end
  end

  // fault latches; ov, uv and soft-off cleared only by reset or enable rising, lockout and guard follow their inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ov_q <= 1'b0;
      uv_q <= 1'b0;
      lo_q <= 1'b0;
      soft_off_q <= 1'b0;
      nvg_q <= 1'b0;
    end
    else
    begin
      // (RULE_12) latch over-voltage
      if (ov_c_q == 8'(OVC))
        ov_q <= 1'b1;
      // (RULE_23) cleared by enable cycle
      else if (en_rise)
        ov_q <= 1'b0;
      // (RULE_19) latch under-voltage
      if (uv_c_q == 8'(UVC))
        uv_q <= 1'b1;
      else if (en_rise)
        uv_q <= 1'b0;
      lo_q <= lo_c_q == 8'(LOC);
      if (other_rail_fault)
        soft_off_q <= 1'b1;
      else if (en_rise)
        soft_off_q <= 1'b0;
      // (RULE_18) guard only when latched
      // (RULE_17) below 0V low sides off
      nvg_q <= ov_q && output_sense_pin < 13'sd0;
    end
  end

  // (RULE_15) other rail soft shutdown
  assign other_rail_shutdown = ov_q | uv_q;

  // gate priority: lockout, faults, then regulation
  always_comb
  begin
    gate_d.hs = 4'h0;
    gate_d.ls = 4'h0;
    // (RULE_21) lockout all off
    if (lo_q || !enable || soft_off_q)
      gate_d = '0;
    else if (ov_q)
    begin
      // (RULE_14) low sides on, high off
      // (RULE_17) guard releases low sides
      gate_d.ls = nvg_q ? 4'h0 : phase_mask(phase_q);
    end
    // (RULE_19) under-voltage all off
    // (RULE_11) over-current all off
    else if (uv_q || oc_q == RFS_OC_OFF)
      gate_d = '0;
    else if (fast_transient_pulse)
      // (RULE_07) pulse overrides on-time
      gate_d.hs = phase_mask(phase_q);
    else
    begin
      gate_d.hs = pwm_in.hs & phase_mask(phase_q);
      // (RULE_03) low sides held off
      gate_d.ls = blk_cnt_q != 3'h0 ? 4'h0 :
        pwm_in.ls & phase_mask(phase_q) & ~pwm_in.hs;
    end
  end

  // registered gate enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_out <= '0;
    else
      gate_out <= gate_d;
  end

endmodule : rfs_supervisor

// ### testbench/rfs_supervisor_asserts.sv
// port checker for the regulator fault supervisor
`timescale 1ns/1ps
module rfs_supervisor_asserts (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic avg_over, // avg current
  input wire logic peak_over, // peak current
  input wire logic supply_below_por, // supply low
  input wire logic signed [12:0] output_sense_pin, // output mV
  input wire logic [1:0] strap_pin_a, // strap a
  input wire logic [1:0] strap_pin_b, // strap b
  input wire rfs_pkg::rfs_gate_t gate_out, // drivers
  input wire logic over_current_alert_n, // alert
  input wire logic other_rail_shutdown, // latch out
  input wire logic diode_emulation, // dem
  input wire logic [1:0] ramp_amp, // ramp
  input wire logic [3:0] slew_comp_bits, // slew
  input wire logic [11:0] core_vref_mv // reference
);
  import rfs_pkg::*;
  int ov_n;
  int uv_n;
  int lo_n;
  int lim;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign lim = (core_vref_mv < 12'd900 ? 900 : int'(core_vref_mv)) + 325;
  // consecutive cycles of each fault condition
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ov_n <= 0;
      uv_n <= 0;
      lo_n <= 0;
    end
    else
    begin
      ov_n <= int'(output_sense_pin) > lim ? ov_n + int'(ov_n < 999) : 0;
      uv_n <= int'(output_sense_pin) <= int'(core_vref_mv) - 500 ?
        uv_n + int'(uv_n < 999) : 0;
      lo_n <= supply_below_por ? lo_n + int'(lo_n < 999) : 0;
    end
  sequence s_neg_hold;
    (other_rail_shutdown && output_sense_pin < 0)[*3];
  endsequence
  a_lockout_off: assert property (lo_n >= 125 |-> gate_out == 8'h00)
    else $error("drivers on in lockout");
  a_uv_all_off: assert property (uv_n >= 125 |-> gate_out == 8'h00)
    else $error("drivers on after undervoltage");
  a_latch_filter: assert property ($rose(other_rail_shutdown)
    |-> ov_n >= 39 || uv_n >= 119) else $error("latch without filter time");
  a_neg_ls_off: assert property (s_neg_hold |=> gate_out.ls == 4'h0)
    else $error("low sides on below zero");
  a_latch_hs_off: assert property (other_rail_shutdown &&
    $past(other_rail_shutdown) |-> gate_out.hs == 4'h0)
    else $error("high side on while latched");
  a_peak_alert: assert property (peak_over |=> !over_current_alert_n)
    else $error("no alert on peak current");
  a_alert_cause: assert property ($fell(over_current_alert_n)
    |-> $past(avg_over) || $past(peak_over)) else $error("alert no cause");
  a_slew_strap: assert property ($past(presetn) |->
    slew_comp_bits == {strap_pin_b, strap_pin_a ^ strap_pin_b})
    else $error("slew bits wrong");
  a_ramp_mode: assert property ($past(presetn) |->
    ramp_amp == (diode_emulation ? 2'h0 : strap_pin_a))
    else $error("ramp amplitude wrong");
endmodule : rfs_supervisor_asserts
bind rfs_supervisor rfs_supervisor_asserts rfs_supervisor_asserts_i (.pclk,
  .presetn, .avg_over, .peak_over, .supply_below_por, .output_sense_pin,
  .strap_pin_a, .strap_pin_b, .gate_out, .over_current_alert_n,
  .other_rail_shutdown, .diode_emulation, .ramp_amp, .slew_comp_bits,
  .core_vref_mv);

// ### testbench/rfs_power_stage.sv
// modulator stand-in: pwm cycle pulses and fixed gate requests
`timescale 1ns/1ps
module rfs_power_stage #(
  parameter int PERIOD = 8
) (
  pclk, // clock
  presetn, // reset, low
  pwm_pulse, // one per pwm cycle
  pwm_in // gate requests
);
  import rfs_pkg::*;
  input wire logic pclk;
  input wire logic presetn;
  output logic pwm_pulse;
  output rfs_pkg::rfs_gate_t pwm_in;
  int cnt_q;
  // alternating high and low side requests
  assign pwm_in = '{hs: 4'h5, ls: 4'ha};
  assign pwm_pulse = (cnt_q == PERIOD - 1);
  // free-running cycle counter
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 0;
    else
      cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
endmodule : rfs_power_stage

// ### testbench/tb_rfs_supervisor.sv
// self-checking bench for the regulator fault supervisor
`timescale 1ns/1ps
`include "rfs_defs.svh"
module tb_rfs_supervisor;
  import rfs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, perr, other_rail_shutdown, diode_emulation;
  logic [1:0] strap_pin_a = 2'h2, strap_pin_b = 2'h1, ramp_amp;
  logic aux_phase1_sense_neg_high = 1'b0, supply_below_por = 1'b0;
  logic avg_over = 1'b0, peak_over = 1'b0, fast_transient_det = 1'b0;
  logic light_load = 1'b0, other_rail_fault = 1'b0, pwm_pulse;
  logic [15:0] current_monitor_pin = 16'h0;
  logic signed [12:0] output_sense_pin = 13'sh0;
  rfs_gate_t pwm_in, gate_out;
  logic over_current_alert_n, fast_transient_pulse;
  logic [3:0] slew_comp_bits;
  logic [11:0] core_vref_mv, nb_vref_mv;
  logic [8:0] lv [4] = '{9'h0, 9'h1, 9'h100, 9'h1ff};
  int err_count = 0;
  int tests_run = 0;
  int n;
  rfs_supervisor rfs_supervisor_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .strap_pin_a, .strap_pin_b,
    .aux_phase1_sense_neg_high, .current_monitor_pin, .output_sense_pin,
    .supply_below_por, .avg_over, .peak_over, .fast_transient_det,
    .light_load, .pwm_pulse, .pwm_in, .other_rail_fault, .gate_out,
    .over_current_alert_n, .other_rail_shutdown, .diode_emulation,
    .ramp_amp, .slew_comp_bits, .fast_transient_pulse, .core_vref_mv,
    .nb_vref_mv);
  rfs_power_stage rfs_power_stage_i (.pclk, .presetn, .pwm_pulse, .pwm_in);
  always #12.5 pclk = ~pclk;
  task test_done;
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(pready, 1'b1);
    if (pready !== 1'b1)
      test_done;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] probe(input int s);
    case (s)
      0: probe = gate_out;
      1: probe = over_current_alert_n;
      default: probe = fast_transient_pulse;
    endcase
  endfunction : probe
  // bounded wait for an output to reach a value
  task waitv(input int s, input logic [31:0] e, input int lim);
    int k;
    k = 0;
    while (probe(s) !== e && k < lim)
    begin
      @(posedge pclk);
      k++;
    end
    chk(probe(s), e);
    if (probe(s) !== e)
      test_done;
  endtask : waitv
  task steady(input int s, input logic [31:0] e, input int cyc);
    repeat (cyc)
    begin
      @(posedge pclk);
      chk(probe(s), e);
    end
  endtask : steady
  task pulses(input int k);
    int c;
    n = 0;
    for (c = 0; c < 200 && n < k; c++)
    begin
      @(posedge pclk);
      n += int'(pwm_pulse === 1'b1);
    end
    chk(n, k);
  endtask : pulses
  task en_cycle;
    apb(1'b1, `RFS_ADDR_CTRL, 32'h0000_0506);
    apb(1'b1, `RFS_ADDR_CTRL, 32'h0000_0507);
    waitv(0, 8'h5a, 10);
  endtask : en_cycle
  // hang guard
  initial
  begin
    repeat (30000) @(posedge pclk);
    err_count++;
    test_done;
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `RFS_ADDR_CTRL, 0);
    chk(rd, `RFS_CTRL_RESET);
    apb(1'b0, `RFS_ADDR_OCP, 0);
    chk(rd, `RFS_OCP_RESET);
    apb(1'b0, `RFS_ADDR_STRAP, 0);
    chk(rd, 32'h27);
    apb(1'b0, 12'h018, 0);
    chk(perr, 1'b1);
    chk(rd, 32'h0000_0000);
    foreach (lv[i])
    begin
      current_monitor_pin <= 16'(lv[i]) * 16'd50;
      repeat (4) @(posedge pclk);
      apb(1'b0, `RFS_ADDR_LOAD, 0);
      chk(rd[8:0], lv[i]);
    end
    light_load <= 1'b1;
    output_sense_pin <= 13'sd800;
    apb(1'b1, `RFS_ADDR_CTRL, 32'h0000_0501);
    waitv(0, 8'h10, 4);
    chk({ramp_amp, diode_emulation}, 3'b001);
    apb(1'b1, `RFS_ADDR_VCMD, 32'd800);
    apb(1'b0, `RFS_ADDR_STATUS, 0);
    chk({rd[13:11], core_vref_mv}, {3'b110, 12'd800});
    output_sense_pin <= 13'sd700;
    apb(1'b1, `RFS_ADDR_VCMD, 32'd700);
    pulses(3);
    chk(gate_out.ls, 4'h0);
    pulses(2);
    steady(0, 8'h5a, 2);
    apb(1'b0, `RFS_ADDR_STATUS, 0);
    chk(rd[13:12], 2'h3);
    light_load <= 1'b0;
    fast_transient_det <= 1'b1;
    @(posedge pclk);
    fast_transient_det <= 1'b0;
    waitv(2, 1'b1, 10);
    for (n = 0; fast_transient_pulse === 1'b1 && n < 50; n++)
      @(posedge pclk);
    chk(n, 5);
    apb(1'b1, `RFS_ADDR_OCP, 32'h0006_0004);
    avg_over <= 1'b1;
    repeat (2) @(posedge pclk);
    avg_over <= 1'b0;
    steady(1, 1'b1, 10);
    avg_over <= 1'b1;
    waitv(1, 1'b0, 12);
    avg_over <= 1'b0;
    waitv(1, 1'b1, 20);
    chk(gate_out, 8'h5a);
    peak_over <= 1'b1;
    waitv(1, 1'b0, 3);
    waitv(0, 8'h00, 15);
    peak_over <= 1'b0;
    en_cycle;
    output_sense_pin <= 13'sd1225;
    repeat (60) @(posedge pclk);
    apb(1'b0, `RFS_ADDR_STATUS, 0);
    chk(rd[1], 1'b0);
    output_sense_pin <= 13'sd1000;
    apb(1'b1, `RFS_ADDR_VCMD, 32'd1000);
    output_sense_pin <= 13'sd1326;
    repeat (30) @(posedge pclk);
    output_sense_pin <= 13'sd1000;
    steady(0, 8'h5a, 4);
    output_sense_pin <= 13'sd1326;
    waitv(0, 8'h0f, 60);
    chk(other_rail_shutdown, 1'b1);
    output_sense_pin <= -13'sd5;
    waitv(0, 8'h00, 8);
    output_sense_pin <= 13'sd1000;
    waitv(0, 8'h0f, 8);
    apb(1'b0, `RFS_ADDR_STATUS, 0);
    chk(rd[1], 1'b1);
    en_cycle;
    output_sense_pin <= -13'sd5;
    steady(0, 8'h5a, 10);
    output_sense_pin <= 13'sd700;
    apb(1'b1, `RFS_ADDR_VCMD, 32'd700);
    output_sense_pin <= 13'sd200;
    waitv(0, 8'h00, 130);
    chk(other_rail_shutdown, 1'b1);
    output_sense_pin <= 13'sd700;
    en_cycle;
    supply_below_por <= 1'b1;
    waitv(0, 8'h00, 130);
    supply_below_por <= 1'b0;
    waitv(0, 8'h5a, 10);
    other_rail_fault <= 1'b1;
    waitv(0, 8'h00, 4);
    other_rail_fault <= 1'b0;
    en_cycle;
    apb(1'b1, `RFS_ADDR_VCMD, 32'h0001_0258);
    apb(1'b0, `RFS_ADDR_VCMD, 0);
    chk(rd, {8'h00, 12'd600, 12'd700});
    chk(nb_vref_mv, 12'd600);
    presetn <= 1'b0;
    strap_pin_a <= 2'h1;
    strap_pin_b <= 2'h3;
    aux_phase1_sense_neg_high <= 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `RFS_ADDR_STRAP, 0);
    chk(rd, 32'h1e);
    apb(1'b1, `RFS_ADDR_VCMD, 32'h0001_01f4);
    apb(1'b0, `RFS_ADDR_STATUS, 0);
    chk({rd[10], nb_vref_mv}, 13'h1000);
    apb(1'b1, `RFS_ADDR_STATUS, 32'h0000_0100);
    apb(1'b0, `RFS_ADDR_STATUS, 0);
    chk(rd[10], 1'b0);
    test_done;
  end
endmodule : tb_rfs_supervisor
